// [verilog/bscd_pkg.sv]
// Purpose: shared constants and types for the board strap configuration decoder
// Assumes: octal base addresses from the strap table, 22-bit bus addresses
// Notes:   register offsets are word aligned byte addresses
package bscd_pkg;

  // avalon register offsets
  localparam logic [5:0] OFS_STRAP_SNAP  = 6'h00;
  localparam logic [5:0] OFS_BASE_ADDR   = 6'h04;
  localparam logic [5:0] OFS_MAINT       = 6'h08;
  localparam logic [5:0] OFS_RATE_CTRL   = 6'h0C;
  localparam logic [5:0] OFS_IRQ_STATUS  = 6'h10;
  localparam logic [5:0] OFS_IRQ_MASK    = 6'h14;
  localparam logic [5:0] OFS_CPU_ERR     = 6'h18;

  // base address tables (octal)
  localparam logic [21:0] BASE_LO_JIN  = 22'o17760100;
  localparam logic [21:0] BASE_LO_JOUT = 22'o17762100;
  localparam logic [21:0] BASE_HI_JIN  = 22'o17775400;
  localparam logic [21:0] BASE_HI_JOUT = 22'o17777400;
  localparam logic [21:0] BASE_STEP    = 22'o40;
  localparam logic [3:0]  ID_LO_FIRST  = 4'h2;
  localparam logic [3:0]  ID_HI_FIRST  = 4'h8;

  // power-up start values (octal)
  localparam logic [15:0] FW_START_PC  = 16'o173000;
  localparam logic [15:0] FW_START_PS  = 16'o340;
  localparam logic [15:0] DBG_START_PS = 16'h0000;
  localparam logic [15:0] TRAP_VECTOR  = 16'o4;

  // field positions
  localparam int MAINT_PWRUP_BIT = 2;
  localparam int MAINT_HALT_BIT  = 3;
  localparam int RATE_WEN_BIT    = 3;
  localparam int CPU_ERR_HALT_BIT = 7;

  // baud rates
  localparam int unsigned BAUD_MAX = 38400;
  localparam int unsigned BAUD_MIN = 300;

  // interrupt status bits
  localparam int IRQ_BREAK_BIT = 0;
  localparam int IRQ_HALT_BIT  = 1;
  localparam int IRQ_TMO_BIT   = 2;
  localparam int IRQ_DMA_BIT   = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    BSCD_AW16,
    BSCD_AW18,
    BSCD_AW22
  } bscd_aw_type;

  // raw strap inputs
  typedef struct packed {
    logic [3:0] id_switch;
    logic       base_jumper;
    logic [1:0] addr_width;
    logic       dma0_rx;
    logic       dma1_pio;
    logic       dma1_tx;
    logic       lock_enable;
    logic       break_enable;
    logic       halt_option;
    logic       pwrup_option;
    logic       prom_16bit;
    logic [2:0] baud_code;
  } bscd_strap_type;

  // run-time event inputs
  typedef struct packed {
    logic break_det;
    logic halt_kernel;
    logic interlock_run;
    logic bus_timeout;
    logic rx_req;
    logic tx_req;
    logic pio_req;
  } bscd_event_type;

  // decoded behaviour outputs
  typedef struct packed {
    logic        standalone;
    logic [21:0] base_addr;
    logic [21:0] addr_mask;
    logic        dma0_req;
    logic        dma1_req;
    logic        bus_lock;
    logic        enter_debugger;
    logic        trap_to_vector;
    logic [15:0] start_pc;
    logic [15:0] start_ps;
    logic        start_in_debugger;
    logic        prom_16bit;
    logic [2:0]  baud_code;
    logic [16:0] baud_rate;
    logic        config_valid;
  } bscd_cfg_type;

endpackage

// [verilog/bscd_decoder.sv]
// Purpose: board strap decoder with avalon-mm register slave
// Assumes: straps synchronous to i_ref_clk, steady while i_rst_n is low
// Notes:   straps are latched on the last reset cycle and held until next reset
//
// Overview of operation
// - low id positions map to 17760100/17762100 bases
// - high id positions map to 17775400/17777400 bases
// - id zero or one means standalone
// - compare only low 16 or 18 bits
// - strap routes serial receiver to dma 0
// - dma 1 from parallel timer or transmitter
// - at most two dma sources accepted
// - strap enables bus lock on interlocked instructions
// - locked timeout traps through vector four
// - break strap gates console debugger entry
// - halt strap in maintenance bit three
// - no halt strap: trap, set error bit
// - power-up strap in maintenance bit two
// - firmware start pc 173000 ps 340
// - prom strap selects 15 or 16 bits
// - rate writable only with control bit three
// - three-bit code, 300 doubling to 38400
// - bus address width 16, 18 or 22
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module bscd_decoder
  import bscd_pkg::*;
(
  // clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  // straps and runtime events
  input  wire bscd_pkg::bscd_strap_type i_strap,
  input  wire bscd_pkg::bscd_event_type i_event,
  // avalon-mm slave
  input  wire logic [5:0]               i_avs_address,
  input  wire logic                     i_avs_read,
  input  wire logic                     i_avs_write,
  input  wire logic [31:0]              i_avs_writedata,
  input  wire logic [3:0]               i_avs_byteenable,
  output logic [31:0]                   o_avs_readdata,
  output logic                          o_avs_waitrequest,
  // decoded configuration and interrupt
  output bscd_pkg::bscd_cfg_type        o_cfg,
  output logic                          o_irq
);
  import bscd_pkg::*;

  // whole module state
  typedef struct packed {
    bscd_strap_type strap;
    bscd_cfg_type   cfg;
    logic           rst_seen;
    logic [2:0]     rate_code;
    logic           rate_wen;
    logic [7:0]     cpu_err;
    logic [3:0]     irq_stat;
    logic [3:0]     irq_mask;
    logic           ack;
    logic [31:0]    rdata;
    logic           irq;
  } bscd_state_type;

  bscd_state_type st_r;
  bscd_state_type st_nxt;

  // base address from id switch and jumper
  function automatic logic [21:0] base_of(input logic [3:0] id, input logic jin);
    logic [21:0] b;
    b = 22'h000000;
    if (id >= ID_HI_FIRST)
      b = (jin ? BASE_HI_JIN : BASE_HI_JOUT) + BASE_STEP * 22'(id - ID_HI_FIRST);
    else if (id >= ID_LO_FIRST)
      b = (jin ? BASE_LO_JIN : BASE_LO_JOUT) + BASE_STEP * 22'(id - ID_LO_FIRST);
    return b;
  endfunction

  // compare mask from address width
  function automatic logic [21:0] mask_of(input logic [1:0] aw);
    logic [21:0] m;
    case (aw)
      BSCD_AW16: m = 22'h00FFFF;
      BSCD_AW18: m = 22'h03FFFF;
      default:   m = 22'h3FFFFF;
    endcase
    return m;
  endfunction

  // baud rate from three-bit code
  function automatic logic [16:0] baud_of(input logic [2:0] code);
    return 17'(BAUD_MIN << code);
  endfunction

  // next state
  always_comb
  begin
    logic [31:0] rd;
    logic        acc;
    logic        dma1_ok;
    rd      = 32'h00000000;
    st_nxt  = st_r;
    acc     = (i_avs_read || i_avs_write) && !st_r.ack;
    dma1_ok = 1'b0;
    st_nxt.ack = acc;

    // straps sampled while reset is held
    if (!i_rst_n)
    begin
      st_nxt           = '0;
      st_nxt.strap     = i_strap;
      st_nxt.rate_code = i_strap.baud_code;
      st_nxt.irq_mask  = IRQ_MASK_RST;
    end
    else
    begin
      // configuration derived from held straps
      st_nxt.rst_seen              = 1'b1;
      st_nxt.cfg.standalone        = (st_r.strap.id_switch < ID_LO_FIRST);
      st_nxt.cfg.base_addr         = base_of(st_r.strap.id_switch, st_r.strap.base_jumper)
                                     & mask_of(st_r.strap.addr_width);
      st_nxt.cfg.addr_mask         = mask_of(st_r.strap.addr_width);
      st_nxt.cfg.prom_16bit        = st_r.strap.prom_16bit;
      st_nxt.cfg.start_in_debugger = st_r.strap.pwrup_option;
      st_nxt.cfg.start_pc          = st_r.strap.pwrup_option ? 16'h0000 : FW_START_PC;
      st_nxt.cfg.start_ps          = st_r.strap.pwrup_option ? DBG_START_PS
                                                            : FW_START_PS;
      st_nxt.cfg.baud_code         = st_r.rate_code;
      st_nxt.cfg.baud_rate         = baud_of(st_r.rate_code);
      st_nxt.cfg.config_valid      = st_r.rst_seen;

      // dma routing; both channel 1 sources at once is refused
      dma1_ok               = !(st_r.strap.dma1_pio && st_r.strap.dma1_tx);
      st_nxt.cfg.dma0_req   = st_r.strap.dma0_rx && i_event.rx_req;
      st_nxt.cfg.dma1_req   = dma1_ok && ((st_r.strap.dma1_pio && i_event.pio_req)
                              || (st_r.strap.dma1_tx && i_event.tx_req));

      // interlocked instructions hold the bus only if enabled
      st_nxt.cfg.bus_lock   = st_r.strap.lock_enable && i_event.interlock_run;

      // debugger entry on break or kernel halt
      st_nxt.cfg.enter_debugger = (st_r.strap.break_enable && i_event.break_det)
                                  || (st_r.strap.halt_option && i_event.halt_kernel);
      st_nxt.cfg.trap_to_vector = (!st_r.strap.halt_option && i_event.halt_kernel)
                                  || (st_r.strap.lock_enable && i_event.interlock_run
                                      && i_event.bus_timeout);

      // register reads
      case (i_avs_address)
        OFS_STRAP_SNAP: rd = 32'(st_r.strap);
        OFS_BASE_ADDR:  rd = {st_r.cfg.standalone, 9'h000, st_r.cfg.base_addr};
        OFS_MAINT:      rd = 32'({st_r.strap.halt_option, st_r.strap.pwrup_option, 2'b00});
        OFS_RATE_CTRL:  rd = {25'h0, st_r.rate_code, st_r.rate_wen, 3'b000};
        OFS_IRQ_STATUS: rd = 32'(st_r.irq_stat);
        OFS_IRQ_MASK:   rd = 32'(st_r.irq_mask);
        OFS_CPU_ERR:    rd = 32'(st_r.cpu_err);
        default:        rd = 32'h00000000;
      endcase
      if (acc && i_avs_read)
        st_nxt.rdata = rd;

      // register writes
      if (acc && i_avs_write && i_avs_byteenable[0])
      begin
        case (i_avs_address)
          OFS_RATE_CTRL:
          begin
            st_nxt.rate_wen = i_avs_writedata[RATE_WEN_BIT];
            if (st_r.rate_wen)
              st_nxt.rate_code = i_avs_writedata[6:4];
          end
          OFS_IRQ_MASK: st_nxt.irq_mask = i_avs_writedata[3:0];
          OFS_CPU_ERR:  st_nxt.cpu_err = st_r.cpu_err & ~i_avs_writedata[7:0];
          default:      st_nxt.rate_wen = st_r.rate_wen;
        endcase
      end

      // read clears status; new events win over the clear
      if (acc && i_avs_read && i_avs_address == OFS_IRQ_STATUS)
        st_nxt.irq_stat = 4'h0;
      if (st_r.strap.break_enable && i_event.break_det)
        st_nxt.irq_stat[IRQ_BREAK_BIT] = 1'b1;
      if (i_event.halt_kernel)
        st_nxt.irq_stat[IRQ_HALT_BIT] = 1'b1;
      if (st_r.strap.lock_enable && i_event.interlock_run && i_event.bus_timeout)
        st_nxt.irq_stat[IRQ_TMO_BIT] = 1'b1;
      if (st_r.strap.dma1_pio && st_r.strap.dma1_tx)
        st_nxt.irq_stat[IRQ_DMA_BIT] = 1'b1;
      if (!st_r.strap.halt_option && i_event.halt_kernel)
        st_nxt.cpu_err[CPU_ERR_HALT_BIT] = 1'b1;
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end
  end

  // state register
  always_ff @(posedge i_ref_clk)
  begin
    st_r <= st_nxt;
  end

  // outputs straight from flops
  assign o_cfg             = st_r.cfg;
  assign o_irq             = st_r.irq;
  assign o_avs_readdata    = st_r.rdata;
  assign o_avs_waitrequest = !st_r.ack;

  // assertions
  chk_standalone_id: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.rst_seen |=> (o_cfg.standalone == ($past(st_r.strap.id_switch) < 4'h2)))
    else $error("standalone decode wrong");
  chk_base_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(st_r.rst_seen) && st_r.strap.id_switch == 4'h5 && st_r.strap.base_jumper
    && st_r.strap.addr_width == 2'h2 && $stable(st_r.strap) |=> o_cfg.base_addr == 22'o17760240)
    else $error("low base address wrong");
  chk_base_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.rst_seen && st_r.strap.id_switch == 4'hF && !st_r.strap.base_jumper
    && st_r.strap.addr_width == 2'h2 |=> o_cfg.base_addr == 22'o17777740)
    else $error("high base address wrong");
  chk_addr_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.rst_seen && st_r.strap.addr_width == 2'h0 |=> o_cfg.base_addr[21:16] == 6'h00)
    else $error("16-bit mask not applied");
  chk_dma_exclusive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.strap.dma1_pio && st_r.strap.dma1_tx |=> !o_cfg.dma1_req)
    else $error("unsupported dma strap passed");
  chk_dma0_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.strap.dma0_rx && i_event.rx_req |=> o_cfg.dma0_req)
    else $error("dma0 request lost");
  chk_lock_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !st_r.strap.lock_enable |=> !o_cfg.bus_lock)
    else $error("bus locked while disabled");
  chk_break_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_event.break_det && !i_event.halt_kernel |=> o_cfg.enter_debugger == $past(st_r.strap.break_enable))
    else $error("break gating wrong");
  chk_halt_trap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_event.halt_kernel && !st_r.strap.halt_option |=> o_cfg.trap_to_vector && st_r.cpu_err[7])
    else $error("halt trap missing");
  chk_fw_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_r.rst_seen && !st_r.strap.pwrup_option |=> o_cfg.start_pc == 16'o173000
    && o_cfg.start_ps == 16'o340)
    else $error("firmware start wrong");
  chk_rate_locked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !st_r.rate_wen |=> st_r.rate_code == $past(st_r.rate_code))
    else $error("rate changed while locked");
  chk_strap_held: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> $stable(st_r.strap))
    else $error("straps changed outside reset");
  chk_bus_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
    else $error("bus answer late");

  // main scenarios
  cov_standalone: cover property (@(posedge i_ref_clk) o_cfg.standalone);
  cov_debug_entry: cover property (@(posedge i_ref_clk) o_cfg.enter_debugger);
  cov_rate_change: cover property (@(posedge i_ref_clk) st_r.rate_wen && i_avs_write
    && i_avs_address == OFS_RATE_CTRL);
  cov_irq: cover property (@(posedge i_ref_clk) o_irq);

endmodule

`default_nettype wire

// [verification/bscd_host_model.sv]
// Purpose: far-side host and arbiter model for the strap decoder
// Assumes: bus lock is seen on the decoder's decoded output
// Notes:   times out a locked cycle only when the bench loads the bus
`timescale 1ns/1ps
`default_nettype none
module bscd_host_model (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // lock seen and bus load
  input  wire logic i_bus_lock,
  input  wire logic i_heavy_load,
  // timeout back to the processor
  output logic      o_bus_timeout
);
  logic [1:0] held_r;

  // a locked cycle on a loaded bus gets three cycles, then times out
  always_ff @(posedge i_ref_clk)
    if (!i_rst_n || !i_bus_lock || !i_heavy_load)
      held_r <= 2'h0;
    else if (held_r != 2'h3)
      held_r <= held_r + 2'h1;

  assign o_bus_timeout = (held_r == 2'h3);
endmodule
`default_nettype wire

// [verification/bscd_decoder_bench.sv]
// Purpose: self-checking bench for the strap decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   read notes queue up for the answer monitor
`timescale 1ns/1ps
`default_nettype none
module bscd_decoder_bench;
  import bscd_pkg::*;
  logic clk, rst_n, rd, wr, heavy, tmo, wait_r, irq;
  logic [5:0] adr;
  logic [31:0] wd, rdata, seed;
  logic [21:0] base, mask;
  logic [63:0] rq[$];
  bscd_strap_type st, s;
  bscd_event_type ev, ev_w;
  bscd_cfg_type cfg, acc, cfg0;
  int n_fail, total_checks, cyc;

  bscd_decoder i_bscd_decoder (.i_ref_clk(clk), .i_rst_n(rst_n), .i_strap(st),
    .i_event(ev_w), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .o_cfg(cfg), .o_irq(irq));
  bscd_host_model i_bscd_host_model (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_bus_lock(cfg.bus_lock), .i_heavy_load(heavy), .o_bus_timeout(tmo));

  // timeout comes from the host model
  always_comb
  begin
    ev_w = ev;
    ev_w.bus_timeout = tmo;
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // each read answer against the oldest note
  always @(posedge clk)
    if (rd && !wait_r)
    begin
      if (rq.size() == 0)
        chk("unexpected read", 32'h0, 32'hFFFFFFFF);
      else
        chk("readdata", rq[0][31:0], rdata & rq[0][63:32]);
      if (rq.size() != 0)
        void'(rq.pop_front());
    end

  // one bus access, held until waitrequest is sampled low
  task automatic avs(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge clk);
    if (!w)
      rq.push_back({m, d & m});
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wait_r);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic do_reset(input bscd_strap_type t);
    @(posedge clk);
    st <= t;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // hold an event, gather every output bit seen high
  task automatic pulse(input bscd_event_type e);
    @(posedge clk);
    ev <= e;
    acc = '0;
    repeat (8)
    begin
      @(posedge clk);
      #1 acc = acc | cfg;
    end
    @(posedge clk);
    ev <= '0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial
  begin
    {rst_n, rd, wr, heavy, adr, wd} = '0;
    ev = '0;
    st = '0;
    seed = 32'h7CA9;
    // sweep every id and jumper with random remaining straps
    for (int i = 0; i < 32; i++)
    begin
      seed = xs(seed);
      s = seed[17:0];
      s.id_switch = i[3:0];
      s.base_jumper = i[4];
      s.addr_width = (seed[25:24] == 2'h3) ? 2'h2 : seed[25:24];
      s.dma1_tx = s.dma1_tx & ~s.dma1_pio;
      do_reset(s);
      mask = (s.addr_width == 2'h0) ? 22'h00FFFF : (s.addr_width == 2'h1) ? 22'h03FFFF : 22'h3FFFFF;
      if (i[3:0] < ID_HI_FIRST)
        base = (s.base_jumper ? BASE_LO_JIN : BASE_LO_JOUT) + 22'(i[3:0] - ID_LO_FIRST) * BASE_STEP;
      else
        base = (s.base_jumper ? BASE_HI_JIN : BASE_HI_JOUT) + 22'(i[3:0] - ID_HI_FIRST) * BASE_STEP;
      chk("standalone", i[3:0] < 4'h2, cfg.standalone);
      if (i[3:0] > 4'h1) chk("base_addr", base & mask, cfg.base_addr);
      chk("prom_16bit", s.prom_16bit, cfg.prom_16bit);
      chk("baud_rate", 32'h12C << s.baud_code, cfg.baud_rate);
      chk("start_ps", s.pwrup_option ? DBG_START_PS : FW_START_PS, cfg.start_ps);
      if (!s.pwrup_option) chk("start_pc", FW_START_PC, cfg.start_pc);
      chk("start_dbg", s.pwrup_option, cfg.start_in_debugger);
      chk("addr_mask", mask, cfg.addr_mask);
      chk("cfg_valid", 32'h1, cfg.config_valid);
      avs(1'b0, OFS_STRAP_SNAP, 32'(s), 32'h3FFFF);
      avs(1'b0, OFS_MAINT, {28'h0, s.halt_option, s.pwrup_option, 2'h0}, 32'hC);
      avs(1'b0, OFS_BASE_ADDR, {i[3:0] < 4'h2, 9'h0, base & mask},
          (i[3:0] < 4'h2) ? 32'h80000000 : 32'h803FFFFF);
      cfg0 = cfg;
      @(posedge clk);
      st <= ~st;
      repeat (3) @(posedge clk);
      #1 chk("held", {cfg0.base_addr, cfg0.baud_code}, {cfg.base_addr, cfg.baud_code});
    end
    avs(1'b0, 6'h3C, 32'h0, 32'hFFFFFFFF);
    // break, halt trap, lock and dma routing with break, lock, dma0_rx and dma1_tx straps enabled
    do_reset('{id_switch:4'h5, addr_width:2'h2, break_enable:1'b1, lock_enable:1'b1,
               dma0_rx:1'b1, dma1_tx:1'b1, baud_code:3'h2, default:1'b0});
    avs(1'b1, OFS_IRQ_MASK, 32'hF, 32'h0);
    pulse('{break_det:1'b1, default:1'b0});
    chk("brk_dbg", 32'h1, acc.enter_debugger);
    chk("irq_set", 32'h1, irq);
    avs(1'b0, OFS_IRQ_STATUS, 32'h1, 32'h1);
    avs(1'b0, OFS_IRQ_STATUS, 32'h0, 32'hF);
    @(posedge clk);
    #1 chk("irq_clr", 32'h0, irq);
    avs(1'b1, OFS_IRQ_MASK, 32'h1, 32'h0);
    pulse('{halt_kernel:1'b1, default:1'b0});
    chk("halt_trap", 32'h1, acc.trap_to_vector);
    chk("halt_nodbg", 32'h0, acc.enter_debugger);
    chk("irq_masked", 32'h0, irq);
    avs(1'b1, OFS_IRQ_MASK, 32'h2, 32'h0);
    @(posedge clk);
    #1 chk("irq_unmask", 32'h1, irq);
    avs(1'b0, OFS_CPU_ERR, 32'h80, 32'h80);
    avs(1'b1, OFS_CPU_ERR, 32'h80, 32'h0);
    avs(1'b0, OFS_CPU_ERR, 32'h0, 32'h80);
    pulse('{interlock_run:1'b1, rx_req:1'b1, tx_req:1'b1, default:1'b0});
    chk("lock_on", 32'h1, acc.bus_lock);
    chk("lock_notrap", 32'h0, acc.trap_to_vector);
    chk("dma0_rx", 32'h1, acc.dma0_req);
    chk("dma1_tx", 32'h1, acc.dma1_req);
    heavy <= 1'b1;
    pulse('{interlock_run:1'b1, default:1'b0});
    chk("lock_trap", 32'h1, acc.trap_to_vector);
    heavy <= 1'b0;
    // everything blocked, halt goes to the debugger, timer feeds channel 1
    do_reset('{id_switch:4'h9, halt_option:1'b1, dma1_pio:1'b1, default:1'b0});
    pulse('{break_det:1'b1, interlock_run:1'b1, rx_req:1'b1, pio_req:1'b1, default:1'b0});
    chk("brk_block", 32'h0, acc.enter_debugger);
    chk("lock_off", 32'h0, acc.bus_lock);
    chk("dma0_off", 32'h0, acc.dma0_req);
    chk("dma1_pio", 32'h1, acc.dma1_req);
    pulse('{halt_kernel:1'b1, default:1'b0});
    chk("halt_dbg", 32'h1, acc.enter_debugger);
    chk("halt_notrap", 32'h0, acc.trap_to_vector);
    // joined dma straps, then the guarded rate change
    do_reset('{id_switch:4'hC, dma1_pio:1'b1, dma1_tx:1'b1, baud_code:3'h1, default:1'b0});
    pulse('{pio_req:1'b1, tx_req:1'b1, default:1'b0});
    chk("dma1_bad", 32'h0, acc.dma1_req);
    avs(1'b0, OFS_IRQ_STATUS, 32'h8, 32'h8);
    avs(1'b1, OFS_RATE_CTRL, 32'h50, 32'h0);
    @(posedge clk);
    #1 chk("rate_locked", 32'h1, cfg.baud_code);
    avs(1'b1, OFS_RATE_CTRL, 32'h8, 32'h0);
    avs(1'b1, OFS_RATE_CTRL, 32'h58, 32'h0);
    @(posedge clk);
    #1 chk("rate_new", 32'h5, cfg.baud_code);
    chk("rate_baud", 32'h12C << 5, cfg.baud_rate);
    avs(1'b0, OFS_RATE_CTRL, 32'h58, 32'h78);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
